// ### rtl/pco_pkg.sv
// Constants shared by the peripheral clock output block.
package pco_pkg;

  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] STATUS_ADDR    = 8'h04;
  localparam logic [7:0] CTRL_RESET     = 8'hE0;
  localparam int         MODE_MSB       = 7;
  localparam int         MODE_LSB       = 5;
  localparam int         CLK_OUT_EN_BIT = 4;
  localparam int         PRESCALE_MSB   = 3;
  localparam int         PRESCALE_LSB   = 2;
  localparam int         IFACE_EN_BIT   = 1;
  localparam logic [7:0] CTRL_WMASK     = 8'hFE;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam logic [7:0] DIV_CODE1_DEF  = 8'h02;
  localparam logic [7:0] DIV_CODE2_DEF  = 8'h04;
  localparam logic [7:0] DIV_CODE3_DEF  = 8'h08;

  typedef enum logic [2:0] {
    PCO_SPI_DIV4   = 3'b000,
    PCO_SPI_DIV16  = 3'b001,
    PCO_SPI_DIV64  = 3'b010,
    PCO_SPI_TBC    = 3'b011,
    PCO_SPI_TMR    = 3'b100,
    PCO_SPI_SLAVE  = 3'b101,
    PCO_I2C_SLAVE  = 3'b110,
    PCO_UNUSED     = 3'b111
  } pco_mode_type;

endpackage

// ### rtl/pco_top.sv
// Peripheral clock output with the shared serial and clock control register.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Output clock is derived from and synchronous to the system clock.
// - Pin carries generated clock when enabled, otherwise ordinary I/O.
// - Enable bit one switches output clock on, zero switches it off.
// - Source is timer zero period match rate halved or divided system clock.
// - Prescale field at bits 3 to 2 selects system clock division ratio.
// - Sleep mode disables the peripheral clock output.
// - Mode codes 000 to 011 select SPI master clock sources.
// - Codes 100 timer master, 101 SPI slave, 110 I2C slave, 111 unused.
// - Interface enable zero floats lines and idles; one operates it.
// - Interface enable acts only if the configuration option allows it.
module pco_top
  import pco_pkg::*;
#(
  parameter logic [7:0] DIV_CODE1 = DIV_CODE1_DEF,
  parameter logic [7:0] DIV_CODE2 = DIV_CODE2_DEF,
  parameter logic [7:0] DIV_CODE3 = DIV_CODE3_DEF
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        TIMER_ZERO_MATCH,
  input  wire logic        SLEEP,
  input  wire logic        SERIAL_OPTION_EN,
  input  wire logic        GPIO_OUT,
  input  wire logic        GPIO_OE,
  output logic             PERIPH_CLOCK_PIN_O,
  output logic             PERIPH_CLOCK_PIN_OE,
  output logic             SERIAL_IFACE_ACTIVE,
  output logic             SPI_MASTER_SEL,
  output logic             SPI_SLAVE_SEL,
  output logic             I2C_SLAVE_SEL,
  output logic             SPI_CLK_FROM_TIMER
);

  logic [7:0] ctrl;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       aw_held;
  logic       w_held;
  logic       wr_hit;
  logic [7:0] div_cnt;
  logic       div_clk;
  logic       tmr_clk;
  logic       clk_out;
  logic       tmr_s1;
  logic       tmr_s2;
  logic       tmr_s3;
  logic       tmr_prev;
  logic       en_prev;

  wire [7:0] next_div_cnt;
  wire       do_write;
  wire       do_read;
  wire [7:0] rd_byte;
  wire       rd_hit;
  wire [1:0] presc = ctrl[PRESCALE_MSB:PRESCALE_LSB];
  wire [2:0] mode  = ctrl[MODE_MSB:MODE_LSB];
  wire       clk_en  = ctrl[CLK_OUT_EN_BIT];
  wire       iface_en = ctrl[IFACE_EN_BIT];
  wire [7:0] ratio;
  wire       tmr_rise;
  wire       out_on;
  wire       div_hi;

  function automatic logic [7:0] ratio_of(input logic [1:0] code);
    logic [7:0] r;
    r = 8'h01;
    if (code == 2'b01) begin
      r = DIV_CODE1;
    end else if (code == 2'b10) begin
      r = DIV_CODE2;
    end else if (code == 2'b11) begin
      r = DIV_CODE3;
    end
    return r;
  endfunction

  // Write path: address and data are held until both arrived.
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign do_write      = aw_held && w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_read       = S_AXI_ARVALID && S_AXI_ARREADY;

  assign rd_byte = (S_AXI_ARADDR == CTRL_ADDR) ? (ctrl & CTRL_WMASK) :
                   {5'h00, SERIAL_IFACE_ACTIVE, out_on, clk_out};
  assign rd_hit  = (S_AXI_ARADDR == CTRL_ADDR) ||
                   (S_AXI_ARADDR == STATUS_ADDR);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        wr_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held  <= 1'b1;
        wr_data <= S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : ctrl;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  assign wr_hit = (wr_addr == CTRL_ADDR);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ctrl         <= CTRL_RESET;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else begin
      if (do_write && wr_hit) begin
        ctrl <= wr_data & CTRL_WMASK;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (do_read) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h000000, rd_hit ? rd_byte : 8'h00};
      S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // The match strobe comes from another domain, so it is filtered.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tmr_s1   <= 1'b0;
      tmr_s2   <= 1'b0;
      tmr_s3   <= 1'b0;
      tmr_prev <= 1'b0;
    end else begin
      tmr_s1 <= TIMER_ZERO_MATCH;
      tmr_s2 <= tmr_s1;
      tmr_s3 <= tmr_s2;
      if (tmr_s2 == tmr_s3) begin
        tmr_prev <= tmr_s3;
      end
    end
  end

  assign tmr_rise = (tmr_s2 == tmr_s3) && tmr_s3 && !tmr_prev;

  assign ratio        = ratio_of(presc);
  assign next_div_cnt = (div_cnt + 8'h01 >= ratio) ? 8'h00 : div_cnt + 8'h01;

  // Fastest registered rate
  // A flop cannot pass the system clock itself, so code 00 toggles every
  // cycle and the pin runs at half the system clock instead.
  assign div_hi = (ratio == 8'h01) ? !div_clk :
                  (next_div_cnt < (ratio >> 1));

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      div_cnt <= 8'h00;
      div_clk <= 1'b0;
      tmr_clk <= 1'b0;
      clk_out <= 1'b0;
      en_prev <= 1'b0;
    end else begin
      div_cnt <= out_on ? next_div_cnt : 8'h00;
      div_clk <= out_on && div_hi;
      if (!out_on) begin
        tmr_clk <= 1'b0;
      end else if (tmr_rise) begin
        tmr_clk <= !tmr_clk;
      end
      en_prev <= out_on;
      clk_out <= (mode == PCO_SPI_TMR) ? tmr_clk : div_clk;
    end
  end

  assign out_on = clk_en && !SLEEP;

  assign PERIPH_CLOCK_PIN_O  = en_prev ? clk_out : GPIO_OUT;
  assign PERIPH_CLOCK_PIN_OE = en_prev ? 1'b1 : GPIO_OE;

  assign SERIAL_IFACE_ACTIVE = iface_en && SERIAL_OPTION_EN;

  assign SPI_MASTER_SEL = SERIAL_IFACE_ACTIVE && (mode <= PCO_SPI_TMR);
  assign SPI_SLAVE_SEL  = SERIAL_IFACE_ACTIVE && (mode == PCO_SPI_SLAVE);
  assign I2C_SLAVE_SEL  = SERIAL_IFACE_ACTIVE && (mode == PCO_I2C_SLAVE);
  assign SPI_CLK_FROM_TIMER = SPI_MASTER_SEL && (mode == PCO_SPI_TMR);

  property p_sleep_off;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (SLEEP || !clk_en) |=> !div_clk;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("Divided clock ran while disabled.");

  property p_pin_drive;
    @(posedge SYS_CLK) disable iff (!RSTN)
      out_on |=> PERIPH_CLOCK_PIN_OE;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("Pin not driven while clock enabled.");

  property p_bit0_zero;
    @(posedge SYS_CLK) disable iff (!RSTN)
      1'b1 |-> !ctrl[0];
  endproperty
  a_bit0_zero: assert property (p_bit0_zero)
    else $error("Unimplemented bit became set.");

  property p_write_en;
    @(posedge SYS_CLK) disable iff (!RSTN)
      do_write && wr_hit |=> clk_en == $past(wr_data[CLK_OUT_EN_BIT]);
  endproperty
  a_write_en: assert property (p_write_en)
    else $error("Enable bit did not follow the write.");

  property p_iface_gate;
    @(posedge SYS_CLK) disable iff (!RSTN)
      !SERIAL_OPTION_EN |-> !SPI_MASTER_SEL && !SPI_SLAVE_SEL;
  endproperty
  a_iface_gate: assert property (p_iface_gate)
    else $error("Interface active without option.");

  property p_iface_off;
    @(posedge SYS_CLK) disable iff (!RSTN)
      !iface_en |-> !SERIAL_IFACE_ACTIVE && !I2C_SLAVE_SEL;
  endproperty
  a_iface_off: assert property (p_iface_off)
    else $error("Interface active while disabled.");

  property p_tmr_half;
    @(posedge SYS_CLK) disable iff (!RSTN)
      out_on && $past(out_on) && tmr_rise |=> tmr_clk != $past(tmr_clk);
  endproperty
  a_tmr_half: assert property (p_tmr_half)
    else $error("Timer clock did not toggle on match.");

  property p_div_period;
    @(posedge SYS_CLK) disable iff (!RSTN)
      out_on && presc == 2'b01 && $stable(ctrl) && div_cnt == 8'h00
        |=> div_cnt == 8'h01;
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("Divider count did not advance.");

  property p_master_mode;
    @(posedge SYS_CLK) disable iff (!RSTN)
      SERIAL_IFACE_ACTIVE && mode == PCO_SPI_DIV16 |-> SPI_MASTER_SEL;
  endproperty
  a_master_mode: assert property (p_master_mode)
    else $error("Master mode not selected.");

  property p_slave_mode;
    @(posedge SYS_CLK) disable iff (!RSTN)
      SERIAL_IFACE_ACTIVE && mode == PCO_SPI_SLAVE |-> !SPI_MASTER_SEL;
  endproperty
  a_slave_mode: assert property (p_slave_mode)
    else $error("Slave mode selected master clock.");

  property p_fast_toggle;
    @(posedge SYS_CLK) disable iff (!RSTN)
      out_on && presc == 2'b00 |=> div_clk != $past(div_clk);
  endproperty
  a_fast_toggle: assert property (p_fast_toggle)
    else $error("Undivided setting did not toggle every cycle.");

  property p_clk_stop;
    @(posedge SYS_CLK) disable iff (!RSTN)
      !clk_en |-> ##2 !clk_out;
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("Output clock kept running after switch off.");

  property p_sleep_pin;
    @(posedge SYS_CLK) disable iff (!RSTN)
      SLEEP |=> PERIPH_CLOCK_PIN_OE == GPIO_OE;
  endproperty
  a_sleep_pin: assert property (p_sleep_pin)
    else $error("Pin still carried the clock in sleep.");

  property p_tmr_source;
    @(posedge SYS_CLK) disable iff (!RSTN)
      mode == PCO_SPI_TMR |=> clk_out == $past(tmr_clk);
  endproperty
  a_tmr_source: assert property (p_tmr_source)
    else $error("Timer source not routed to the output clock.");

  property p_read_bit0;
    @(posedge SYS_CLK) disable iff (!RSTN)
      do_read && S_AXI_ARADDR == CTRL_ADDR |=> !S_AXI_RDATA[0];
  endproperty
  a_read_bit0: assert property (p_read_bit0)
    else $error("Unimplemented bit read back as one.");

  c_write: cover property (@(posedge SYS_CLK) do_write && wr_hit);
  c_read: cover property (@(posedge SYS_CLK) do_read && rd_hit);
  c_tmr: cover property (@(posedge SYS_CLK) out_on && tmr_rise);
  c_sleep: cover property (@(posedge SYS_CLK) clk_en && SLEEP);
  c_fast: cover property (@(posedge SYS_CLK) out_on && presc == 2'b00);

endmodule

// ### tb/pco_partner.sv
// Model of the external hardware that receives the peripheral clock.
`timescale 1ns/1ps
module pco_partner (
  input  wire logic clk,
  input  wire logic pin,
  input  wire logic pin_oe,
  input  wire logic clear,
  output int        edges
);
  logic last = 1'b0;
  // Edges sampled only while driven.
  // Sampling on the system clock works because the output is synchronous.
  always @(posedge clk) begin
    last <= pin;
    if (clear)
      edges <= 0;
    else if (pin_oe && pin && !last)
      edges <= edges + 1;
  end
endmodule

// ### tb/pco_top_tb_top.sv
// Self-checking bench for the peripheral clock output block.
`timescale 1ns/1ps
module pco_top_tb_top;
  import pco_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        tmr = 1'b0, sleep = 1'b0, opt = 1'b0;
  logic        gout = 1'b0, goe = 1'b0, clr = 1'b0;
  logic [2:0]  tc = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, e;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] rdata, rd;
  logic        pin_o, pin_oe, act, msel, ssel, isel, tsel;
  int          edges, fails, total_checks, ctrl_model;
  int          div_tab[4] = '{2, 2, 4, 6};

  pco_top #(.DIV_CODE1(8'h02), .DIV_CODE2(8'h04), .DIV_CODE3(8'h06))
  i_pco_top (.SYS_CLK(sys_clk), .RSTN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TIMER_ZERO_MATCH(tmr),
    .SLEEP(sleep), .SERIAL_OPTION_EN(opt), .GPIO_OUT(gout), .GPIO_OE(goe),
    .PERIPH_CLOCK_PIN_O(pin_o), .PERIPH_CLOCK_PIN_OE(pin_oe),
    .SERIAL_IFACE_ACTIVE(act), .SPI_MASTER_SEL(msel),
    .SPI_SLAVE_SEL(ssel), .I2C_SLAVE_SEL(isel), .SPI_CLK_FROM_TIMER(tsel));

  pco_partner i_pco_partner (.clk(sys_clk), .pin(pin_o), .pin_oe(pin_oe),
    .clear(clr), .edges(edges));

  initial forever #5 sys_clk = ~sys_clk;

  // Timer match pulses every eight cycles.
  always @(posedge sys_clk) begin
    tc <= tc + 3'h1;
    tmr <= tc[2];
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({bvalid, bresp}, {1'b1, RESP_OKAY});
    ctrl_model = d[7:0] & 8'hFE;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // Counts output edges over a window and allows one edge of phase slack.
  task automatic window(input int cyc, input int exp);
    repeat (4) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge sys_clk);
    chk(edges >= exp - 1 && edges <= exp + 1, 1'b1);
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(81434));
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    axr(CTRL_ADDR);
    chk({rr, rd}, {RESP_OKAY, 32'hE0});
    axw(CTRL_ADDR, 32'hFFFF_FFFF);
    axr(CTRL_ADDR);
    chk(rd, ctrl_model);
    axr(8'h40);
    chk({rr, rd}, {RESP_SLVERR, 32'h0});
    for (int m = 0; m < 16; m++) begin
      opt <= m[3];
      axw(CTRL_ADDR, {24'h0, m[2:0], 3'b000, 1'($urandom), 1'b0});
      e = ctrl_model[1] && m[3];
      chk({act, msel, ssel, isel, tsel},
          {e, e && m[2:0] < 5, e && m[2:0] == 5, e && m[2:0] == 6,
           e && m[2:0] == 4});
      axr(STATUS_ADDR);
      chk(rd & 32'h6, e ? 32'h4 : 32'h0);
    end
    // Output periods in cycles; code 00 toggles on every cycle.
    for (int p = 0; p < 4; p++) begin
      gout <= 1'($urandom);
      goe <= 1'($urandom);
      axw(CTRL_ADDR, {27'h0, 1'b1, p[1:0], 2'b00});
      window(160, 160 / div_tab[p]);
      chk(pin_oe, 1'b1);
      axr(STATUS_ADDR);
      chk(rd & 32'h2, 32'h2);
    end
    axw(CTRL_ADDR, 32'h90);
    window(160, 10);
    sleep <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({pin_oe, pin_o}, {goe, gout});
    window(160, 0);
    sleep <= 1'b0;
    axw(CTRL_ADDR, 32'h80);
    gout <= ~gout;
    goe <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({pin_oe, pin_o}, {goe, gout});
    tally_and_finish;
  end
endmodule
